// ==== shared/fep_defs.svh ====
// constants of the flash error status and program-flash protection block
// assumes: included by bare name wherever offsets or field bits are needed
`ifndef FEP_DEFS_SVH
`define FEP_DEFS_SVH

// register indices; byte address is four times the index
`define FEP_IDX_W          4
`define FEP_IDX_CONFIG     4'h4
`define FEP_IDX_ERR_CFG    4'h5
`define FEP_IDX_STATUS     4'h6
`define FEP_IDX_ERR_STAT   4'h7
`define FEP_IDX_PROT       4'h8
`define FEP_IDX_LSB        2

// field bit positions
`define FEP_SF_BIT         0
`define FEP_DF_BIT         1
`define FEP_IGN_SF_BIT     4
`define FEP_SF_IE_BIT      0
`define FEP_VIOL_BIT       4

// reset values
`define FEP_PROT_FULL      8'h7F
`define FEP_BYTE_ZERO      8'h00
`define FEP_WORD_ZERO      32'h00000000

// configuration byte address fetched during the reset sequence
`define FEP_CFG_ADDR       24'hFFFE0C

// program flash limits
`define FEP_PF_BASE        24'hFF8000
`define FEP_PF_TOP         24'hFFFFFF

// high window start per size code: 2, 4, 8, 16 KB ending at the top
`define FEP_HI_START0      24'hFFF800
`define FEP_HI_START1      24'hFFF000
`define FEP_HI_START2      24'hFFE000
`define FEP_HI_START3      24'hFFC000

// low window end per size code: 1, 2, 4, 8 KB from the base
`define FEP_LO_END0        24'hFF83FF
`define FEP_LO_END1        24'hFF87FF
`define FEP_LO_END2        24'hFF8FFF
`define FEP_LO_END3        24'hFF9FFF

// allowed scenario moves, bit index {from,to}, scenario {open,hdis,ldis}
`define FEP_TRANS_OK       64'hFF5A3C18080C0A0F

`endif

// ==== shared/fep_pkg.sv ====
// types of the flash error status and program-flash protection block
// assumes: compiled before any core file
package fep_pkg;

  // program-flash protection register layout, bit 7 down to bit 0
  typedef struct packed {
    logic       op_enable;
    logic       rsv_nv;
    logic       hi_dis;
    logic [1:0] hi_size;
    logic       lo_dis;
    logic [1:0] lo_size;
  } fep_prot_t;

  // one flash array read outcome, same clock domain
  typedef struct packed {
    logic done;
    logic single_err;
    logic double_err;
    logic busy_blk;
  } fep_rd_evt_t;

  // one program or erase request from the command engine
  typedef struct packed {
    logic        valid;
    logic        is_write;
    logic        is_blk_erase;
    logic [23:0] addr;
  } fep_cmd_t;

  typedef enum logic {fep_st_load, fep_st_run} fep_state_t;

endpackage

// ==== core/fep_range_check.sv ====
// address check against the program-flash protection windows
// assumes: purely combinational, registered by the caller
`timescale 1ns/1ps
`include "fep_defs.svh"

module fep_range_check (
  // protection setting
  input  wire fep_pkg::fep_prot_t prot,
  // address of a program or sector erase
  input  wire logic [23:0]        addr,
  // results
  output logic                    addr_prot,
  output logic                    block_prot
);

  logic [23:0] hi_start;
  logic [23:0] lo_end;
  logic        in_pf;
  logic        in_win;

  // window limits from the size codes
  always_comb begin
    case (prot.hi_size)
      2'h0:    hi_start = `FEP_HI_START0;
      2'h1:    hi_start = `FEP_HI_START1;
      2'h2:    hi_start = `FEP_HI_START2;
      default: hi_start = `FEP_HI_START3;
    endcase
    case (prot.lo_size)
      2'h0:    lo_end = `FEP_LO_END0;
      2'h1:    lo_end = `FEP_LO_END1;
      2'h2:    lo_end = `FEP_LO_END2;
      default: lo_end = `FEP_LO_END3;
    endcase
  end

  // enabled windows act as protected or unprotected by the enable bit
  always_comb begin
    in_pf  = (addr >= `FEP_PF_BASE) && (addr <= `FEP_PF_TOP);
    in_win = (!prot.hi_dis && (addr >= hi_start))
           || (!prot.lo_dis && (addr <= lo_end));
    if (!in_pf) begin
      addr_prot = 1'b0;
    end else if (prot.op_enable) begin
      addr_prot = in_win;
    end else begin
      addr_prot = !in_win;
    end
    // windows never cover the whole block, so open-low always leaves some
    block_prot = !(prot.op_enable && prot.hi_dis && prot.lo_dis);
  end

endmodule

// ==== core/fep_top.sv ====
// flash error status flags and program-flash protection register
// assumes: classic wishbone master on clk_sys, read path and command
// engine on the same clock, configuration byte delivered after reset
`timescale 1ns/1ps
`include "fep_defs.svh"

// How it works
// - double fault or busy-block read sets double flag
// - double flag cleared only by writing one
// - single fault sets single flag unless ignored
// - single flag cleared only by writing one
// - pending flag must be cleared first
// - flags stored two cycles after the read
// - error status readable, writable only to clear
// - protection writes accepted only when protection grows
// - protection loaded from configuration byte after reset
// - double fault on load leaves flash fully protected
// - protected program or erase rejected, violation set
// - block erase refused if any sector protected
// - enable and disables select protection scenario
// - high disable controls window at flash top
// - high size writable only while high disabled
// - high sizes 2, 4, 8, 16 KB
// - low disable controls window at flash base
// - low size writable only while low disabled
// - low sizes 1, 2, 4, 8 KB
// - single flag with enable requests interrupt
// - disallowed scenario transitions ignored whole
// - violation cleared by one, blocks new commands
module fep_top #(
  parameter int ADR_W = 6
) (
  // clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  rst,
  // wishbone slave
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [ADR_W-1:0]      wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic      [31:0]           wb_dat_o,
  output logic                       wb_ack_o,
  // array read outcomes
  input  wire fep_pkg::fep_rd_evt_t  rd_evt,
  // configuration byte fetch
  output logic                       cfg_fetch,
  output logic      [23:0]           cfg_addr,
  input  wire logic                  cfg_valid,
  input  wire logic [7:0]            cfg_byte,
  input  wire logic                  cfg_double_err,
  // command check
  input  wire fep_pkg::fep_cmd_t     cmd,
  output logic                       cmd_accept,
  output logic                       cmd_reject,
  // status out
  output logic                       single_fault_irq,
  output logic      [7:0]            prot_out
);

  // refused at elaboration: the index and byte-lane bits must both fit
  if (ADR_W < `FEP_IDX_W + `FEP_IDX_LSB) begin : g_adr_w_bad
    $error("ADR_W too small for the register map");
  end

  fep_pkg::fep_state_t  state;
  fep_pkg::fep_prot_t   prot;
  fep_pkg::fep_prot_t   next_prot;
  fep_pkg::fep_prot_t   wr_fields;
  fep_pkg::fep_rd_evt_t rd_stage;
  logic                 single_fault_flag;
  logic                 double_fault_flag;
  logic                 ignore_single_fault;
  logic                 single_fault_irq_enable;
  logic                 protection_violation_flag;
  logic                 addr_prot;
  logic                 block_prot;
  logic                 bus_req;
  logic                 wr_lane0;
  logic [`FEP_IDX_W-1:0] idx;
  logic [7:0]           wr_byte;
  logic                 wr_err_stat;
  logic                 wr_status;
  logic                 wr_prot;
  logic                 cmd_bad;
  logic                 cmd_go;
  logic [31:0]          rd_word;

  // a new bus cycle is taken once; ack drops the request for one cycle
  assign bus_req     = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign idx         = wb_adr_i[`FEP_IDX_LSB +: `FEP_IDX_W];
  assign wr_lane0    = bus_req && wb_we_i && wb_sel_i[0];
  assign wr_byte     = wb_dat_i[7:0];
  assign wr_fields   = wr_byte;
  assign wr_err_stat = wr_lane0 && (idx == `FEP_IDX_ERR_STAT);
  assign wr_status   = wr_lane0 && (idx == `FEP_IDX_STATUS);
  assign wr_prot     = wr_lane0 && (idx == `FEP_IDX_PROT);

  fep_range_check u_range (
    .prot       (prot),
    .addr       (cmd.addr),
    .addr_prot  (addr_prot),
    .block_prot (block_prot)
  );

  // scenario move lookup, scenario number is {enable, hdis, ldis}
  function automatic logic trans_ok(input logic [2:0] from_s,
                                    input logic [2:0] to_s);
    logic [63:0] tbl;
    tbl = `FEP_TRANS_OK;
    return tbl[{from_s, to_s}];
  endfunction

  // reset sequence: wait for the configuration byte, then run
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state <= fep_pkg::fep_st_load;
    end else begin
      case (state)
        fep_pkg::fep_st_load: begin
          if (cfg_valid) begin
            state <= fep_pkg::fep_st_run;
          end
        end
        fep_pkg::fep_st_run: state <= fep_pkg::fep_st_run;
        default:             state <= fep_pkg::fep_st_load;
      endcase
    end
  end

  // fetch request runs while loading; address is a fixed constant
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cfg_fetch <= 1'b1;
      cfg_addr  <= `FEP_CFG_ADDR;
    end else begin
      cfg_fetch <= (state == fep_pkg::fep_st_load) && !cfg_valid;
      cfg_addr  <= `FEP_CFG_ADDR;
    end
  end

  // candidate protection value from a software write
  always_comb begin
    next_prot           = prot;
    next_prot.op_enable = wr_fields.op_enable;
    next_prot.hi_dis    = wr_fields.hi_dis;
    next_prot.lo_dis    = wr_fields.lo_dis;
    // reserved bit keeps its loaded value
    next_prot.rsv_nv    = prot.rsv_nv;
    if (prot.hi_dis) begin
      next_prot.hi_size = wr_fields.hi_size;
    end
    if (prot.lo_dis) begin
      next_prot.lo_size = wr_fields.lo_size;
    end
  end

  // protection register: loaded at reset sequence, only grows after
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      prot <= `FEP_PROT_FULL;
    end else if (state == fep_pkg::fep_st_load) begin
      if (cfg_valid && cfg_double_err) begin
        prot <= `FEP_PROT_FULL;
      end else if (cfg_valid) begin
        prot <= cfg_byte;
      end
    end else if (wr_prot && trans_ok({prot.op_enable, prot.hi_dis,
                                      prot.lo_dis},
                                     {next_prot.op_enable, next_prot.hi_dis,
                                      next_prot.lo_dis})) begin
      prot <= next_prot;
    end
  end

  // read outcomes are staged one cycle before reaching the flags
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rd_stage <= '0;
    end else begin
      rd_stage.done       <= rd_evt.done;
      rd_stage.double_err <= rd_evt.done
                          && (rd_evt.double_err || rd_evt.busy_blk);
      rd_stage.single_err <= rd_evt.done && !ignore_single_fault
                          && (rd_evt.single_err || rd_evt.busy_blk);
      rd_stage.busy_blk   <= rd_evt.done && rd_evt.busy_blk;
    end
  end

  // sticky flags; a new fault wins over a same-cycle clear
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      double_fault_flag <= 1'b0;
      single_fault_flag <= 1'b0;
    end else begin
      double_fault_flag <= rd_stage.double_err
        || (double_fault_flag
            && !(wr_err_stat && wr_byte[`FEP_DF_BIT]));
      single_fault_flag <= rd_stage.single_err
        || (single_fault_flag
            && !(wr_err_stat && wr_byte[`FEP_SF_BIT]));
    end
  end

  // configuration bits kept here: ignore single fault, irq enable
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ignore_single_fault     <= 1'b0;
      single_fault_irq_enable <= 1'b0;
    end else begin
      if (wr_lane0 && (idx == `FEP_IDX_CONFIG)) begin
        ignore_single_fault <= wr_byte[`FEP_IGN_SF_BIT];
      end
      if (wr_lane0 && (idx == `FEP_IDX_ERR_CFG)) begin
        single_fault_irq_enable <= wr_byte[`FEP_SF_IE_BIT];
      end
    end
  end

  // interrupt follows the flag one cycle later
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      single_fault_irq <= 1'b0;
    end else begin
      single_fault_irq <= single_fault_flag
                       && single_fault_irq_enable;
    end
  end

  // command check; a pending violation refuses without a new flag
  assign cmd_go  = cmd.valid && (state == fep_pkg::fep_st_run);
  assign cmd_bad = (cmd.is_write && addr_prot)
                || (cmd.is_blk_erase && block_prot);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cmd_accept <= 1'b0;
      cmd_reject <= 1'b0;
    end else begin
      cmd_accept <= cmd_go && !protection_violation_flag && !cmd_bad;
      cmd_reject <= cmd_go
                 && (protection_violation_flag || cmd_bad);
    end
  end

  // violation flag, set only while clear, so a write-one clear always takes effect
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      protection_violation_flag <= 1'b0;
    end else begin
      protection_violation_flag <=
        (cmd_go && !protection_violation_flag && cmd_bad)
        || (protection_violation_flag
            && !(wr_status && wr_byte[`FEP_VIOL_BIT]));
    end
  end

  // read mux; unmapped indices read zero
  always_comb begin
    rd_word = `FEP_WORD_ZERO;
    case (idx)
      `FEP_IDX_CONFIG:   rd_word[`FEP_IGN_SF_BIT] = ignore_single_fault;
      `FEP_IDX_ERR_CFG:  rd_word[`FEP_SF_IE_BIT] = single_fault_irq_enable;
      `FEP_IDX_STATUS:   rd_word[`FEP_VIOL_BIT] = protection_violation_flag;
      `FEP_IDX_ERR_STAT: begin
        rd_word[`FEP_DF_BIT] = double_fault_flag;
        rd_word[`FEP_SF_BIT] = single_fault_flag;
      end
      `FEP_IDX_PROT:     rd_word[7:0] = prot;
      default:           rd_word = `FEP_WORD_ZERO;
    endcase
  end

  // one-cycle registered answer to every access, mapped or not
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= `FEP_WORD_ZERO;
    end else begin
      wb_ack_o <= bus_req;
      if (bus_req && !wb_we_i) begin
        wb_dat_o <= rd_word;
      end
    end
  end

  // protection value mirrored out from its own flop
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      prot_out <= `FEP_PROT_FULL;
    end else begin
      prot_out <= prot;
    end
  end

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_double_set: assert property (
    (rd_evt.done && rd_evt.double_err) |-> ##2 double_fault_flag)
    else $error("double fault not recorded two cycles after read");

  a_single_ign: assert property (
    (rd_evt.done && rd_evt.single_err && ignore_single_fault
     && !rd_evt.busy_blk && !single_fault_flag)
    |-> ##2 !single_fault_flag)
    else $error("ignored single fault was recorded");

  a_df_zero_hold: assert property (
    (double_fault_flag && !(wr_err_stat && wr_byte[`FEP_DF_BIT]))
    |=> double_fault_flag)
    else $error("double flag lost without write of one");

  a_sf_clear_one: assert property (
    (single_fault_flag && wr_err_stat && wr_byte[`FEP_SF_BIT]
     && !rd_stage.single_err) |=> !single_fault_flag)
    else $error("single flag not cleared by write of one");

  a_prot_grows: assert property (
    ($past(state) == fep_pkg::fep_st_run && prot != $past(prot))
    |-> trans_ok({$past(prot.op_enable), $past(prot.hi_dis),
                  $past(prot.lo_dis)},
                 {prot.op_enable, prot.hi_dis, prot.lo_dis}))
    else $error("protection moved to a disallowed scenario");

  a_hi_size_lock: assert property (
    (state == fep_pkg::fep_st_run && !prot.hi_dis) |=> $stable(prot.hi_size))
    else $error("high size changed while high window enabled");

  a_lo_size_lock: assert property (
    (state == fep_pkg::fep_st_run && !prot.lo_dis) |=> $stable(prot.lo_size))
    else $error("low size changed while low window enabled");

  a_load_dbl_full: assert property (
    (state == fep_pkg::fep_st_load && cfg_valid && cfg_double_err)
    |=> (prot == `FEP_PROT_FULL) ##1 (prot_out == `FEP_PROT_FULL))
    else $error("double fault on load did not fully protect");

  a_viol_refuse: assert property (
    (cmd_go && protection_violation_flag) |=> (cmd_reject && !cmd_accept))
    else $error("command launched while violation pending");

  a_viol_set: assert property (
    (cmd_go && !protection_violation_flag && cmd_bad)
    |=> (cmd_reject && protection_violation_flag))
    else $error("protected access not rejected");

  a_irq_follow: assert property (
    (single_fault_flag && single_fault_irq_enable) |=> single_fault_irq)
    else $error("single fault interrupt missing");

  c_double_seen: cover property (rd_evt.done && rd_evt.double_err ##2
                                 double_fault_flag);
  c_prot_write: cover property (wr_prot ##1 $changed(prot));
  c_viol_block: cover property (cmd_go && protection_violation_flag);
  c_load_dbl: cover property (state == fep_pkg::fep_st_load && cfg_valid
                              && cfg_double_err);

endmodule

// ==== verif/flash_error_and_protection_tb.sv ====
// self-checking bench for the flash error flags and protection register
// assumes: fep_pkg compiled first, fep_defs.svh on the include path
`timescale 1ns/1ps
`include "fep_defs.svh"

module flash_error_and_protection_tb;
  // clock and reset
  logic                  clk_sys = 1'b0;
  logic                  rst;
  // wishbone master side
  logic                  wb_cyc_i;
  logic                  wb_stb_i;
  logic                  wb_we_i;
  logic [5:0]            wb_adr_i;
  logic [3:0]            wb_sel_i;
  logic [31:0]           wb_dat_i;
  logic [31:0]           wb_dat_o;
  logic                  wb_ack_o;
  // array reads, configuration fetch, commands
  fep_pkg::fep_rd_evt_t  rd_evt;
  logic                  cfg_fetch;
  logic [23:0]           cfg_addr;
  logic                  cfg_valid;
  logic [7:0]            cfg_byte;
  logic                  cfg_double_err;
  fep_pkg::fep_cmd_t     cmd;
  logic                  cmd_accept;
  logic                  cmd_reject;
  logic                  single_fault_irq;
  logic [7:0]            prot_out;
  // bookkeeping
  int                    errors;
  int                    tests_run;
  logic [1:0]            hs;
  logic [7:0]            pb;
  logic [23:0]           hi;
  logic [23:0]           lo;

  always #25 clk_sys = ~clk_sys;

  fep_top #(.ADR_W(6)) u_dut (
    .clk_sys          (clk_sys),
    .rst              (rst),
    .wb_cyc_i         (wb_cyc_i),
    .wb_stb_i         (wb_stb_i),
    .wb_we_i          (wb_we_i),
    .wb_adr_i         (wb_adr_i),
    .wb_sel_i         (wb_sel_i),
    .wb_dat_i         (wb_dat_i),
    .wb_dat_o         (wb_dat_o),
    .wb_ack_o         (wb_ack_o),
    .rd_evt           (rd_evt),
    .cfg_fetch        (cfg_fetch),
    .cfg_addr         (cfg_addr),
    .cfg_valid        (cfg_valid),
    .cfg_byte         (cfg_byte),
    .cfg_double_err   (cfg_double_err),
    .cmd              (cmd),
    .cmd_accept       (cmd_accept),
    .cmd_reject       (cmd_reject),
    .single_fault_irq (single_fault_irq),
    .prot_out         (prot_out)
  );

  // verdict and the single exit of the run
  task automatic end_of_test();
    $display("comparisons %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one classic cycle; entered just after a rising edge
  task automatic wb_xfer(input logic we, input logic [3:0] idx,
                         input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_sel_i <= 4'h1;
    wb_adr_i <= {idx, 2'b00};
    wb_dat_i <= {24'h000000, d};
    do begin
      @(posedge clk_sys);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    if (wb_ack_o !== 1'b1) begin
      errors++;
      end_of_test();
    end
    // idle cycle so the slave can drop ack
    @(posedge clk_sys);
  endtask

  task automatic wr(input logic [3:0] idx, input logic [7:0] d);
    logic [7:0] q;
    wb_xfer(1'b1, idx, d, q);
  endtask

  task automatic rd_chk(input logic [3:0] idx, input logic [7:0] exp);
    logic [7:0] q;
    wb_xfer(1'b0, idx, 8'h00, q);
    chk({16'h0000, q}, {16'h0000, exp});
  endtask

  // one array read outcome, then room for the staged flag update
  task automatic evt(input logic s, input logic d, input logic b);
    rd_evt <= {1'b1, s, d, b};
    @(posedge clk_sys);
    rd_evt <= '0;
    repeat (2) @(posedge clk_sys);
  endtask

  // program or erase request; answer pulse awaited under a bound
  task automatic run_cmd(input logic w, input logic blk,
                         input logic [23:0] a, input logic acc);
    int n;
    n = 0;
    cmd <= {1'b1, w, blk, a};
    @(posedge clk_sys);
    cmd <= '0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (cmd_accept !== 1'b1 && cmd_reject !== 1'b1 && n < 4);
    if (cmd_accept !== 1'b1 && cmd_reject !== 1'b1) begin
      errors++;
      end_of_test();
    end
    chk({22'h0, cmd_accept, cmd_reject}, {22'h0, acc, !acc});
  endtask

  // full reset, then deliver the configuration byte
  task automatic load_cfg(input logic [7:0] b, input logic dbl);
    rst <= 1'b1;
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    chk({16'h0000, prot_out}, 24'h00007F);
    chk({23'h0, cfg_fetch}, 24'h000001);
    chk(cfg_addr, 24'hFFFE0C);
    cfg_valid      <= 1'b1;
    cfg_byte       <= b;
    cfg_double_err <= dbl;
    @(posedge clk_sys);
    cfg_valid      <= 1'b0;
    cfg_double_err <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk({23'h0, cfg_fetch}, 24'h000000);
  endtask

  initial begin
    errors = 0;
    tests_run = 0;
    rst = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 6'h00;
    wb_sel_i = 4'h1;
    wb_dat_i = 32'h00000000;
    rd_evt = '0;
    cfg_valid = 1'b0;
    cfg_byte = 8'h00;
    cfg_double_err = 1'b0;
    cmd = '0;
    // both windows protected, every size code, edges of each window
    for (int c = 0; c < 4; c++) begin
      hs = c[1:0];
      // reserved bit left erased in the stored byte
      pb = {1'b1, 1'b1, 1'b0, hs, 1'b0, hs};
      hi = 24'h000000 - (24'h000800 << c);
      lo = 24'hFF8000 + (24'h000400 << c) - 24'h000001;
      load_cfg(pb, 1'b0);
      rd_chk(`FEP_IDX_PROT, pb);
      run_cmd(1'b1, 1'b0, hi, 1'b0);
      rd_chk(`FEP_IDX_STATUS, 8'h10);
      wr(`FEP_IDX_STATUS, 8'h10);
      run_cmd(1'b1, 1'b0, hi - 24'h000001, 1'b1);
      run_cmd(1'b1, 1'b0, lo, 1'b0);
      wr(`FEP_IDX_STATUS, 8'h10);
      run_cmd(1'b1, 1'b0, lo + 24'h000001, 1'b1);
    end
    // sizes locked while their windows are enabled
    wr(`FEP_IDX_PROT, 8'h80);
    rd_chk(`FEP_IDX_PROT, 8'hDB);
    // a pending violation blocks even a legal command
    run_cmd(1'b1, 1'b0, 24'hFFC000, 1'b0);
    run_cmd(1'b1, 1'b0, 24'hFFA000, 1'b0);
    wr(`FEP_IDX_STATUS, 8'h00);
    rd_chk(`FEP_IDX_STATUS, 8'h10);
    wr(`FEP_IDX_STATUS, 8'h10);
    run_cmd(1'b1, 1'b0, 24'hFFA000, 1'b1);
    run_cmd(1'b0, 1'b1, 24'hFF8000, 1'b0);
    wr(`FEP_IDX_STATUS, 8'h10);
    // shrinking moves are dropped whole, growing ones taken
    wr(`FEP_IDX_PROT, 8'hA4);
    rd_chk(`FEP_IDX_PROT, 8'hDB);
    wr(`FEP_IDX_PROT, 8'h00);
    rd_chk(`FEP_IDX_PROT, 8'hDB);
    wr(`FEP_IDX_PROT, 8'h24);
    rd_chk(`FEP_IDX_PROT, 8'h7F);
    chk({16'h0000, prot_out}, 24'h00007F);
    run_cmd(1'b1, 1'b0, 24'hFFA000, 1'b0);
    wr(`FEP_IDX_STATUS, 8'h10);
    run_cmd(1'b1, 1'b0, 24'h001000, 1'b1);
    // no protection, then open windows with the rest protected
    load_cfg(8'hFF, 1'b0);
    rd_chk(`FEP_IDX_PROT, 8'hFF);
    run_cmd(1'b1, 1'b0, 24'hFFFFFF, 1'b1);
    run_cmd(1'b0, 1'b1, 24'hFF8000, 1'b1);
    wr(`FEP_IDX_PROT, 8'h00);
    rd_chk(`FEP_IDX_PROT, 8'h40);
    run_cmd(1'b1, 1'b0, 24'hFFF800, 1'b1);
    run_cmd(1'b1, 1'b0, 24'hFF83FF, 1'b1);
    run_cmd(1'b1, 1'b0, 24'hFFF7FF, 1'b0);
    wr(`FEP_IDX_STATUS, 8'h10);
    // closing the low opening protects it again
    wr(`FEP_IDX_PROT, 8'h04);
    rd_chk(`FEP_IDX_PROT, 8'h44);
    run_cmd(1'b1, 1'b0, 24'hFF83FF, 1'b0);
    wr(`FEP_IDX_STATUS, 8'h10);
    // low window only, then a high one added with a fresh size
    load_cfg(8'hFB, 1'b0);
    run_cmd(1'b1, 1'b0, 24'hFF9FFF, 1'b0);
    wr(`FEP_IDX_STATUS, 8'h10);
    run_cmd(1'b1, 1'b0, 24'hFFFFFF, 1'b1);
    wr(`FEP_IDX_PROT, 8'h88);
    rd_chk(`FEP_IDX_PROT, 8'hCB);
    run_cmd(1'b1, 1'b0, 24'hFFF000, 1'b0);
    wr(`FEP_IDX_STATUS, 8'h10);
    // damaged configuration byte leaves flash fully protected
    load_cfg(8'hA4, 1'b1);
    rd_chk(`FEP_IDX_PROT, 8'h7F);
    run_cmd(1'b0, 1'b1, 24'hFF8000, 1'b0);
    wr(`FEP_IDX_STATUS, 8'h10);
    // fault flags: set, write zero, write one
    evt(1'b0, 1'b1, 1'b0);
    rd_chk(`FEP_IDX_ERR_STAT, 8'h02);
    wr(`FEP_IDX_ERR_STAT, 8'h00);
    rd_chk(`FEP_IDX_ERR_STAT, 8'h02);
    wr(`FEP_IDX_ERR_STAT, 8'h02);
    rd_chk(`FEP_IDX_ERR_STAT, 8'h00);
    wr(`FEP_IDX_ERR_CFG, 8'h01);
    evt(1'b1, 1'b0, 1'b0);
    rd_chk(`FEP_IDX_ERR_STAT, 8'h01);
    chk({23'h0, single_fault_irq}, 24'h000001);
    wr(`FEP_IDX_ERR_STAT, 8'h02);
    rd_chk(`FEP_IDX_ERR_STAT, 8'h01);
    wr(`FEP_IDX_ERR_STAT, 8'h01);
    rd_chk(`FEP_IDX_ERR_STAT, 8'h00);
    chk({23'h0, single_fault_irq}, 24'h000000);
    // ignored single faults; busy-block reads hit both flags unless single faults are ignored
    wr(`FEP_IDX_CONFIG, 8'h10);
    evt(1'b1, 1'b0, 1'b0);
    rd_chk(`FEP_IDX_ERR_STAT, 8'h00);
    evt(1'b0, 1'b0, 1'b1);
    rd_chk(`FEP_IDX_ERR_STAT, 8'h02);
    wr(`FEP_IDX_CONFIG, 8'h00);
    wr(`FEP_IDX_ERR_STAT, 8'h03);
    evt(1'b0, 1'b0, 1'b1);
    rd_chk(`FEP_IDX_ERR_STAT, 8'h03);
    wr(`FEP_IDX_ERR_STAT, 8'h03);
    // writes cannot set flags; unmapped place reads zero
    wr(`FEP_IDX_ERR_STAT, 8'hFF);
    rd_chk(`FEP_IDX_ERR_STAT, 8'h00);
    wr(4'hF, 8'hFF);
    rd_chk(4'hF, 8'h00);
    end_of_test();
  end
endmodule
